// file: verilog/ctg_regs.sv
/*
 Trim value and general-purpose pin register bank of a delta-sigma converter, on classic Wishbone.
 Assumes a single clock, synchronous active-low reset and a Wishbone master in classic single cycles.
*/
// Local design decision: register access over Wishbone.
`timescale 1ns/1ps
`include "ctg_defs.svh"
module ctg_regs
    import ctg_pkg::*;
#(
    parameter int PINS = 4,
    parameter bit SMALL_VARIANT = 1'b0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    input wire logic [PINS-1:0] pin_in,
    output logic [PINS-1:0] pin_out,
    output logic [PINS-1:0] pin_oe,
    output logic [PINS-1:0] pin_digital,
    output logic [23:0] offset_trim_value,
    output logic [23:0] gain_trim_value
);
    logic take;
    logic [7:0] index;
    logic wr_ok;
    logic [PINS-1:0] pin_sampled;
    logic [7:0] ofs_low_q, ofs_low_d;
    logic [7:0] ofs_mid_q, ofs_mid_d;
    logic [7:0] ofs_high_q, ofs_high_d;
    logic [7:0] gain_low_q, gain_low_d;
    logic [7:0] gain_mid_q, gain_mid_d;
    logic [7:0] gain_high_q, gain_high_d;
    logic [PINS-1:0] way_q, way_d;
    logic [PINS-1:0] level_q, level_d;
    logic [PINS-1:0] setup_q, setup_d;
    logic [31:0] rdat_d;
    logic [PINS-1:0] out_d, oe_d, dig_d;
    logic [PINS-1:0] rdat_d_pin;
    logic [31:0] rdat_full;
    logic [23:0] ofs_trim_d;
    logic [23:0] gain_trim_d;

    // ==========================================================================
    // Bus handshake and pin synchroniser.
    ctg_wb_slave u_slave (
        .clk(clk),
        .rst_n(rst_n),
        .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i),
        .wb_ack_o(wb_ack_o),
        .take_o(take)
    );

    ctg_pin_sync #(.WIDTH(PINS)) u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_i(pin_in),
        .pin_o(pin_sampled)
    );

    assign index = {2'b00, wb_adr_i[7:2]};
    assign wr_ok = take && wb_we_i && wb_sel_i[0];

    // ==========================================================================
    // Register writes.
    always_comb begin
        ofs_low_d = ofs_low_q;
        ofs_mid_d = ofs_mid_q;
        ofs_high_d = ofs_high_q;
        gain_low_d = gain_low_q;
        gain_mid_d = gain_mid_q;
        gain_high_d = gain_high_q;
        way_d = way_q;
        level_d = level_q;
        setup_d = setup_q;
        if (wr_ok) begin
            case (index)
                `CTG_IDX_OFS_LOW: ofs_low_d = wb_dat_i[7:0];
                `CTG_IDX_OFS_MID: ofs_mid_d = wb_dat_i[7:0];
                `CTG_IDX_OFS_HIGH: ofs_high_d = wb_dat_i[7:0];
                `CTG_IDX_GAIN_LOW: gain_low_d = wb_dat_i[7:0];
                `CTG_IDX_GAIN_MID: gain_mid_d = wb_dat_i[7:0];
                `CTG_IDX_GAIN_HIGH: gain_high_d = wb_dat_i[7:0];
                `CTG_IDX_WAY_LEVEL: begin
                    way_d = wb_dat_i[`CTG_WAY_MSB:`CTG_WAY_LSB];
                    level_d = wb_dat_i[`CTG_LEVEL_MSB:`CTG_LEVEL_LSB];
                end
                `CTG_IDX_PIN_SETUP: setup_d = wb_dat_i[`CTG_SETUP_MSB:`CTG_SETUP_LSB];
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            ofs_low_q <= `CTG_RST_ZERO;
            ofs_mid_q <= `CTG_RST_ZERO;
            ofs_high_q <= `CTG_RST_ZERO;
            gain_low_q <= `CTG_RST_ZERO;
            gain_mid_q <= `CTG_RST_ZERO;
            gain_high_q <= `CTG_RST_GAIN_HIGH;
            way_q <= '0;
            level_q <= '0;
            setup_q <= '0;
        end else begin
            ofs_low_q <= ofs_low_d;
            ofs_mid_q <= ofs_mid_d;
            ofs_high_q <= ofs_high_d;
            gain_low_q <= gain_low_d;
            gain_mid_q <= gain_mid_d;
            gain_high_q <= gain_high_d;
            way_q <= way_d;
            level_q <= level_d;
            setup_q <= setup_d;
        end
    end

    // ==========================================================================
    // Read data and pin drive.
    always_comb begin
        rdat_d = 32'h0000_0000;
        if (take && !wb_we_i) begin
            case (index)
                `CTG_IDX_OFS_LOW: rdat_d[7:0] = ofs_low_q;
                `CTG_IDX_OFS_MID: rdat_d[7:0] = ofs_mid_q;
                `CTG_IDX_OFS_HIGH: rdat_d[7:0] = ofs_high_q;
                `CTG_IDX_GAIN_LOW: rdat_d[7:0] = gain_low_q;
                `CTG_IDX_GAIN_MID: rdat_d[7:0] = gain_mid_q;
                `CTG_IDX_GAIN_HIGH: rdat_d[7:0] = gain_high_q;
                `CTG_IDX_WAY_LEVEL: begin
                    rdat_d[`CTG_WAY_MSB:`CTG_WAY_LSB] = way_q;
                    rdat_d[`CTG_LEVEL_MSB:`CTG_LEVEL_LSB] = level_q;
                end
                `CTG_IDX_PIN_SETUP: rdat_d[`CTG_SETUP_MSB:`CTG_SETUP_LSB] = setup_q;
                default: rdat_d = 32'h0000_0000;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < PINS; g++) begin : g_pin
            always_comb begin
                dig_d[g] = setup_q[g];
                oe_d[g] = setup_q[g] && !way_q[g];
                out_d[g] = oe_d[g] && level_q[g];
                if (way_q[g] && setup_q[g] && take && !wb_we_i && index == `CTG_IDX_WAY_LEVEL) begin
                    rdat_d_pin[g] = pin_sampled[g];
                end else begin
                    rdat_d_pin[g] = level_q[g];
                end
            end
        end
    endgenerate

    always_comb begin
        rdat_full = rdat_d;
        if (index == `CTG_IDX_WAY_LEVEL && take && !wb_we_i) begin
            rdat_full[PINS-1:0] = rdat_d_pin;
        end
    end

    // ==========================================================================
    // Trim values assembled from their bytes.
    always_comb begin
        ofs_trim_d = {ofs_high_d, ofs_mid_d, ofs_low_d};
        gain_trim_d = {gain_high_d, gain_mid_d, gain_low_d};
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wb_dat_o <= 32'h0000_0000;
            pin_out <= '0;
            pin_oe <= '0;
            pin_digital <= '0;
            offset_trim_value <= 24'h00_0000;
            gain_trim_value <= 24'h40_0000;
        end else begin
            wb_dat_o <= rdat_full;
            pin_out <= out_d;
            pin_oe <= oe_d;
            pin_digital <= dig_d;
            offset_trim_value <= ofs_trim_d;
            gain_trim_value <= gain_trim_d;
        end
    end

    // ==========================================================================
    // Checks on the bus handshake, idle read data and unmapped reads.
    a_ack_pulse: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o
        |=> !wb_ack_o)
        else $error("ack held for more than one cycle");
    a_ack_answer: assert property (@(posedge clk) disable iff (!rst_n)
        wb_cyc_i && wb_stb_i && !$past(wb_cyc_i && wb_stb_i)
        |=> wb_ack_o)
        else $error("request not acknowledged in the next cycle");
    a_dat_idle: assert property (@(posedge clk) disable iff (!rst_n)
        !wb_ack_o
        |-> wb_dat_o == 32'h0000_0000)
        else $error("read data shown without ack");
    a_unmapped_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && (index < `CTG_IDX_OFS_LOW || index > `CTG_IDX_PIN_SETUP))
        |-> wb_dat_o == 32'h0000_0000)
        else $error("unmapped read not zero");

    // ==========================================================================
    // Checks on reset values.
    a_gain_reset: assert property (@(posedge clk) $rose(rst_n) |-> gain_high_q == `CTG_RST_GAIN_HIGH)
        else $error("gain high byte not 40h after reset");
    a_ofs_reset: assert property (@(posedge clk)
        $rose(rst_n)
        |-> ofs_low_q == `CTG_RST_ZERO && ofs_mid_q == `CTG_RST_ZERO && ofs_high_q == `CTG_RST_ZERO)
        else $error("offset trim bytes not zero after reset");
    a_gain_lm_reset: assert property (@(posedge clk)
        $rose(rst_n)
        |-> gain_low_q == `CTG_RST_ZERO && gain_mid_q == `CTG_RST_ZERO)
        else $error("gain low or middle byte not zero after reset");
    a_pin_reset: assert property (@(posedge clk)
        $rose(rst_n)
        |-> way_q == '0 && level_q == '0 && setup_q == '0)
        else $error("pin registers not zero after reset");
    a_small_off: assert property (@(posedge clk)
        $rose(rst_n) && SMALL_VARIANT
        |-> pin_oe == '0 && pin_digital == '0 && pin_out == '0)
        else $error("pins of the small variant usable after reset");
    a_trim_reset: assert property (@(posedge clk)
        $rose(rst_n)
        |-> offset_trim_value == 24'h00_0000 && gain_trim_value == 24'h40_0000)
        else $error("trim outputs wrong after reset");

    // ==========================================================================
    // Checks on register writes.
    a_ofs_low_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_OFS_LOW |=> ##1 offset_trim_value[7:0] == $past(wb_dat_i[7:0], 2))
        else $error("offset low byte not on trim output");
    a_ofs_mid_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_OFS_MID
        |=> ofs_mid_q == $past(wb_dat_i[7:0]))
        else $error("offset middle byte write lost");
    a_ofs_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_OFS_HIGH |=> ofs_high_q == $past(wb_dat_i[7:0]))
        else $error("offset high byte write lost");
    a_gain_low_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_GAIN_LOW |=> gain_low_q == $past(wb_dat_i[7:0]))
        else $error("gain low byte write lost");
    a_gain_mid_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_GAIN_MID |=> gain_mid_q == $past(wb_dat_i[7:0]))
        else $error("gain middle byte write lost");
    a_gain_high_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_GAIN_HIGH
        |=> gain_high_q == $past(wb_dat_i[7:0]))
        else $error("gain high byte write lost");
    a_way_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_WAY_LEVEL
        |=> way_q == $past(wb_dat_i[`CTG_WAY_MSB:`CTG_WAY_LSB]))
        else $error("pin direction write lost");
    a_level_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_WAY_LEVEL
        |=> level_q == $past(wb_dat_i[`CTG_LEVEL_MSB:`CTG_LEVEL_LSB]))
        else $error("pin level write lost");
    a_setup_write: assert property (@(posedge clk) disable iff (!rst_n)
        wr_ok && index == `CTG_IDX_PIN_SETUP
        |=> setup_q == $past(wb_dat_i[`CTG_SETUP_MSB:`CTG_SETUP_LSB]))
        else $error("pin setup write lost");
    a_no_sel_write: assert property (@(posedge clk) disable iff (!rst_n)
        take && wb_we_i && !wb_sel_i[0]
        |=> $stable(ofs_low_q) && $stable(ofs_mid_q) && $stable(gain_high_q) && $stable(setup_q))
        else $error("write without byte select stored");

    // ==========================================================================
    // Checks on read data.
    a_setup_upper: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_PIN_SETUP) |-> wb_dat_o[7:4] == 4'h0)
        else $error("setup upper bits not zero");
    a_level_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_WAY_LEVEL && !way_q[0])
        |-> wb_dat_o[0] == $past(level_q[0]))
        else $error("level bit read wrong");
    a_ofs_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_OFS_HIGH)
        |-> wb_dat_o[7:0] == $past(ofs_high_q))
        else $error("offset high byte read wrong");
    a_gain_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_GAIN_HIGH)
        |-> wb_dat_o[7:0] == $past(gain_high_q))
        else $error("gain high byte read wrong");
    a_way_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_WAY_LEVEL)
        |-> wb_dat_o[`CTG_WAY_MSB:`CTG_WAY_LSB] == $past(way_q))
        else $error("pin direction read wrong");
    a_setup_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_PIN_SETUP)
        |-> wb_dat_o[`CTG_SETUP_MSB:`CTG_SETUP_LSB] == $past(setup_q))
        else $error("pin setup read wrong");
    a_in_read: assert property (@(posedge clk) disable iff (!rst_n)
        wb_ack_o && $past(!wb_we_i && index == `CTG_IDX_WAY_LEVEL && way_q[0] && setup_q[0])
        |-> wb_dat_o[0] == $past(pin_sampled[0]))
        else $error("input pin level read wrong");

    // ==========================================================================
    // Checks on pin drive and the pin synchroniser.
    a_out_drive: assert property (@(posedge clk) disable iff (!rst_n)
        setup_q[0] && !way_q[0] |=> pin_oe[0] && pin_out[0] == $past(level_q[0]))
        else $error("digital output pin not driven");
    a_in_float: assert property (@(posedge clk) disable iff (!rst_n)
        way_q[0] |=> !pin_oe[0])
        else $error("input pin driven");
    a_analog_off: assert property (@(posedge clk) disable iff (!rst_n)
        !setup_q[0] |=> !pin_oe[0] && !pin_digital[0])
        else $error("analogue pin left digital");
    a_oe_all: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n)
        |-> pin_oe == $past(setup_q & ~way_q))
        else $error("pin drive enables wrong");
    a_out_all: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n)
        |-> pin_out == $past(setup_q & ~way_q & level_q))
        else $error("pin drive levels wrong");
    a_dig_follow: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n)
        |-> pin_digital == $past(setup_q))
        else $error("digital use flags wrong");
    a_sync_delay: assert property (@(posedge clk) disable iff (!rst_n)
        $past(rst_n, 2) && $past(rst_n)
        |-> pin_sampled == $past(pin_in, 2))
        else $error("pin synchroniser delay wrong");

    // ==========================================================================
    // Checks on trim outputs.
    a_ofs_out: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |-> offset_trim_value == {ofs_high_q, ofs_mid_q, ofs_low_q})
        else $error("offset trim output differs from its bytes");
    a_gain_out: assert property (@(posedge clk) disable iff (!rst_n)
        1'b1
        |-> gain_trim_value == {gain_high_q, gain_mid_q, gain_low_q})
        else $error("gain trim output differs from its bytes");
endmodule

// file: verilog/ctg_defs.svh
/*
 Register offsets, field positions and reset values of the trim and pin register bank.
 Assumes byte-wide registers, each on one aligned 32-bit Wishbone word at four times its index.
*/
`ifndef CTG_DEFS_SVH
`define CTG_DEFS_SVH

// ==========================================================================
// Register indices.
`define CTG_IDX_OFS_LOW 8'h0A
`define CTG_IDX_OFS_MID 8'h0B
`define CTG_IDX_OFS_HIGH 8'h0C
`define CTG_IDX_GAIN_LOW 8'h0D
`define CTG_IDX_GAIN_MID 8'h0E
`define CTG_IDX_GAIN_HIGH 8'h0F
`define CTG_IDX_WAY_LEVEL 8'h10
`define CTG_IDX_PIN_SETUP 8'h11

// ==========================================================================
// Reset values.
`define CTG_RST_ZERO 8'h00
`define CTG_RST_GAIN_HIGH 8'h40

// ==========================================================================
// Field positions.
`define CTG_WAY_MSB 7
`define CTG_WAY_LSB 4
`define CTG_LEVEL_MSB 3
`define CTG_LEVEL_LSB 0
`define CTG_SETUP_MSB 3
`define CTG_SETUP_LSB 0

`endif

// file: verilog/ctg_pkg.sv
/*
 Types shared by the trim and pin register bank.
 Assumes nothing of its surroundings.
*/
package ctg_pkg;
    typedef enum logic [1:0] {
        CTG_IDLE,
        CTG_ACK,
        CTG_DONE
    } ctg_bus_state_t;
endpackage

// file: verilog/ctg_wb_slave.sv
/*
 Classic Wishbone slave handshake: one acknowledge per request, one cycle after it rises.
 Assumes a master that holds its request until it sees ack and then drops cyc for a cycle.
*/
`timescale 1ns/1ps
module ctg_wb_slave
    import ctg_pkg::*;
(
    input wire logic clk,
    input wire logic rst_n,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    output logic take_o
);
    ctg_bus_state_t state_q;
    ctg_bus_state_t state_d;
    logic ack_d;

    // ==========================================================================
    // Handshake state.
    always_comb begin
        state_d = state_q;
        ack_d = 1'b0;
        case (state_q)
            CTG_IDLE: begin
                if (wb_cyc_i && wb_stb_i) begin
                    state_d = CTG_ACK;
                    ack_d = 1'b1;
                end
            end
            CTG_ACK: state_d = CTG_DONE;
            CTG_DONE: begin
                if (!(wb_cyc_i && wb_stb_i)) begin
                    state_d = CTG_IDLE;
                end
            end
            default: state_d = CTG_IDLE;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            state_q <= CTG_IDLE;
            wb_ack_o <= 1'b0;
        end else begin
            state_q <= state_d;
            wb_ack_o <= ack_d;
        end
    end

    assign take_o = ack_d;
endmodule

// file: verilog/ctg_pin_sync.sv
/*
 Two-stage synchroniser for the external pin levels.
 Assumes the pins may change at any time with respect to clk.
*/
`timescale 1ns/1ps
module ctg_pin_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] pin_o
);
    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = pin_i;
        sync_d = meta_q;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            meta_q <= '0;
            pin_o <= '0;
        end else begin
            meta_q <= meta_d;
            pin_o <= sync_d;
        end
    end
endmodule

// file: bench/tb.sv
/*
 Self-checking bench for the trim value and pin register bank, driven over classic Wishbone.
 Assumes the bank answers each request with a one-cycle ack and holds read data with it.
*/
`timescale 1ns/1ps
module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [7:0] adr = 8'h00;
    logic [3:0] sel = 4'h0;
    logic [31:0] wdat = 32'h0000_0000;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic [3:0] pin_in = 4'h3;
    logic [3:0] pin_out;
    logic [3:0] pin_oe;
    logic [3:0] pin_digital;
    logic [23:0] offset_trim_value;
    logic [23:0] gain_trim_value;
    int num_errors = 0;
    int comparisons = 0;
    logic [7:0] idx [8] = '{8'h0A, 8'h0B, 8'h0C, 8'h0D, 8'h0E, 8'h0F, 8'h10, 8'h11};
    logic [7:0] rstv [8] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h40, 8'h00, 8'h00};

    ctg_regs #(.PINS(4), .SMALL_VARIANT(1'b1)) dut (
        .clk(clk), .rst_n(rst_n), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(wb_dat_o),
        .wb_ack_o(wb_ack_o), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
        .pin_digital(pin_digital), .offset_trim_value(offset_trim_value),
        .gain_trim_value(gain_trim_value)
    );

    always #5 clk = ~clk;

    // ==========================================================================
    // Closing and comparison.
    task automatic end_sim();
        $display("Counts: %0d comparisons, %0d mismatches.", comparisons, num_errors);
        if (num_errors == 0 && comparisons > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] t=%0t %s: got %h, expected %h", $time, what, got, exp);
        end
    endtask

    // ==========================================================================
    // Wishbone classic single cycles.
    task automatic wb_access(input logic w, input logic [7:0] a, input logic [31:0] d,
                             input logic [3:0] s, output logic [31:0] rd);
        @(posedge clk);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        sel <= s;
        wdat <= d;
        do begin
            @(posedge clk);
        end while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        logic [31:0] rd;
        wb_access(1'b1, a, {24'h00_0000, d}, 4'h1, rd);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [31:0] rd;
        wb_access(1'b0, a, 32'h0000_0000, 4'h0, rd);
        check(rd, {24'h00_0000, exp}, $sformatf("read %h", a));
    endtask

    task automatic do_reset();
        rst_n <= 1'b0;
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    // ==========================================================================
    // Tests.
    initial begin
        do_reset();
        for (int i = 0; i < 8; i++) rd_chk(8'(idx[i] * 4), rstv[i]);
        check({8'h00, offset_trim_value}, 32'h0000_0000, "offset");
        check({8'h00, gain_trim_value}, 32'h0040_0000, "gain");
        check({28'h000_0000, pin_oe | pin_digital}, 32'h0000_0000, "pins off");
        $display("Test reset values done.");
        for (int i = 0; i < 6; i++) wr(8'(idx[i] * 4), 8'((i + 1) * 17));
        for (int i = 0; i < 6; i++) rd_chk(8'(idx[i] * 4), 8'((i + 1) * 17));
        check({8'h00, offset_trim_value}, 32'h0033_2211, "offset");
        check({8'h00, gain_trim_value}, 32'h0066_5544, "gain");
        $display("Test trim registers done.");
        wr(8'h44, 8'hFF);
        rd_chk(8'h44, 8'h0F);
        check({28'h000_0000, pin_digital}, 32'h0000_000F, "digital");
        wr(8'h40, 8'h5A);
        rd_chk(8'h40, 8'h5B);
        check({28'h000_0000, pin_oe}, 32'h0000_000A, "oe");
        check({28'h000_0000, pin_out & pin_oe}, 32'h0000_000A, "out");
        pin_in <= 4'h4;
        repeat (4) @(posedge clk);
        rd_chk(8'h40, 8'h5E);
        wr(8'h44, 8'h00);
        @(posedge clk);
        check({28'h000_0000, pin_oe | pin_digital}, 32'h0000_0000, "analogue");
        $display("Test pins done.");
        begin
            logic [31:0] rd;
            wb_access(1'b1, 8'h28, 32'h0000_00FF, 4'h0, rd);
        end
        rd_chk(8'h28, 8'h11);
        check({8'h00, offset_trim_value}, 32'h0033_2211, "offset kept");
        wr(8'h48, 8'hFF);
        rd_chk(8'h48, 8'h00);
        rd_chk(8'h24, 8'h00);
        $display("Test refused accesses done.");
        do_reset();
        rd_chk(8'h3C, 8'h40);
        rd_chk(8'h30, 8'h00);
        check({8'h00, gain_trim_value}, 32'h0040_0000, "gain");
        $display("Test second reset done.");
        end_sim();
    end

    initial begin
        #100us;
        num_errors++;
        end_sim();
    end
endmodule
